/* File: design/nlec_classifier.sv */
// Error classifier for the external endpoint of the bridge.
// Assumes event strobes and the packet summary come from the same clock.
// Limitation: one packet summary per cycle; events of one class merge.
`timescale 1ns/1ns

// Notes on behaviour
// - Symbol, disparity, framing and decode errors are correctable.
// - Link training protocol breaches are uncorrectable.
// - Packet ending ENDB with inverted LCRC is discarded silently.
// - Bad packet LCRC is correctable.
// - Unexpected non-duplicate sequence number is correctable.
// - Bad link packet, replay timeout, replay rollover are correctable.
// - Flow control initialisation violation is uncorrectable.
// - Ack/Nak for unknown sequence is uncorrectable.
// - All reports go toward the external root only.
// - Internally owned packet errors are left to their ingress stack.
// - End-to-end CRC on terminating packets is never checked.
// - Malformed packet is fatal; unexpected completion is non-fatal.
// - No flow control checks; receiver overflow ignored.
// - Never raise completer abort or completion timeout.
// - Malformed checks only on packets received at a port.
// - Length must be below the programmed max payload.
// - I/O and config reads: one dword, TC0, ATTR0, size 4 or 3.
// - I/O and config writes: one dword, TC0, ATTR0, size 5 or 4.
// - 32-bit memory write count is length plus four with CRC.
module nlec_classifier
    import nlec_pkg::*;
(
    input  wire logic                        clock_in,
    input  wire logic                        sys_rst_in,
    input  wire nlec_pkg::nlec_link_evt_type link_evt_in,
    input  wire nlec_pkg::nlec_tlp_type      tlp_in,
    input  wire logic [LEN_W-1:0]            max_payload_setting_in,
    output logic                             correctable_out,
    output logic                             nonfatal_out,
    output logic                             fatal_out,
    output logic                             discard_out,
    output logic                             report_external_out
);
    import nlec_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    // Only the class pulses are stored; nothing spans two packets
    typedef struct packed {
        nlec_err_type err;
    } nlec_state_type;

    nlec_state_type state_reg;
    nlec_state_type state_next;
    logic           malformed;
    logic           phys_corr;
    logic           dll_corr;
    logic           phys_uncorr;
    logic           dll_uncorr;
    logic           uncorr;
    logic           tlp_corr;
    logic           tlp_fatal;
    logic           tlp_nonfatal;
    logic           tlp_drop;
    logic           ext_tlp;

    // Length and shape checks
    nlec_tlp_check u_check (
        .tlp_in                 (tlp_in),
        .max_payload_setting_in (max_payload_setting_in),
        .malformed_out          (malformed)
    );

    // ****************************************************************
    // Classification
    // ****************************************************************
    // Priority per packet: discard, then link-level correctable, then
    // malformed or unexpected completion. A packet the link layer has
    // already rejected carries no trustworthy header, so its shape is
    // not judged. Link strobes are independent of the packet path and
    // may add a second class in the same cycle.
    // Classes merge so concurrent events of one class give one pulse
    always_comb begin
        ext_tlp = tlp_in.valid && !tlp_in.int_owned;
        phys_corr = link_evt_in.bad_symbol | link_evt_in.disparity
                    | link_evt_in.framing | link_evt_in.decode;
        dll_corr = link_evt_in.bad_dllp | link_evt_in.replay_timeout
                   | link_evt_in.replay_rollover;
        phys_uncorr = link_evt_in.train_violation;
        dll_uncorr = link_evt_in.fc_init_violation | link_evt_in.acknak_bad_seq;
        uncorr = phys_uncorr | dll_uncorr;
        tlp_drop = ext_tlp && tlp_in.ends_endb && tlp_in.lcrc_inverted;
        // bad LCRC; sequence mismatch not duplicate
        tlp_corr = ext_tlp && !tlp_drop
                   && (tlp_in.lcrc_bad
                       || (tlp_in.seq_mismatch && !tlp_in.duplicate));
        tlp_fatal = ext_tlp && !tlp_drop && !tlp_corr && tlp_in.from_port
                    && malformed;
        tlp_nonfatal = ext_tlp && !tlp_drop && !tlp_corr
                       && tlp_in.unexpected_cpl;
        // has_ecrc only sizes the packet; CRC is never compared
        // no flow control or overflow inputs exist
        // no abort or timeout class is produced
        // Copy first so a later field cannot be left unassigned
        state_next = state_reg;
        // Uncorrectable has no line of its own; it rides on non-fatal
        state_next.err.correctable = phys_corr | dll_corr | tlp_corr;
        state_next.err.nonfatal    = tlp_nonfatal | uncorr;
        state_next.err.fatal       = tlp_fatal;
        state_next.err.discard     = tlp_drop;
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    // Registered pulses; reset clears them so no stale class leaks out
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // separate pulse per class
    assign correctable_out = state_reg.err.correctable;
    assign nonfatal_out    = state_reg.err.nonfatal;
    assign fatal_out       = state_reg.err.fatal;
    assign discard_out     = state_reg.err.discard;
    assign report_external_out = 1'b1;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    // Antecedents avoid the merge nets except in chk_train_not_corr and chk_corr_single, so a fault in the shared
    // merge logic still shows elsewhere; all checks but chk_reset_quiet sleep while reset is high.
    chk_phys_correctable: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (link_evt_in.decode | link_evt_in.framing) |=> correctable_out)
        else $error("physical error not correctable");

    chk_train_uncorr: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        link_evt_in.train_violation |=> nonfatal_out)
        else $error("training violation not reported");

    chk_endb_silent: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (tlp_in.valid && !tlp_in.int_owned && tlp_in.ends_endb && tlp_in.lcrc_inverted
         && link_evt_in == '0) |=> (discard_out && !correctable_out && !fatal_out))
        else $error("nullified packet raised an error");

    chk_lcrc_corr: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (tlp_in.valid && !tlp_in.int_owned && tlp_in.lcrc_bad && !tlp_in.ends_endb)
        |=> correctable_out)
        else $error("bad LCRC not correctable");

    chk_dup_quiet: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (tlp_in.valid && tlp_in.seq_mismatch && tlp_in.duplicate && !tlp_in.lcrc_bad
         && link_evt_in == '0) |=> !correctable_out)
        else $error("duplicate packet flagged");

    chk_replay_corr: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        link_evt_in.replay_rollover |=> correctable_out)
        else $error("replay rollover not correctable");

    chk_acknak_uncorr: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        link_evt_in.acknak_bad_seq |=> nonfatal_out)
        else $error("ack/nak sequence not reported");

    chk_internal_skip: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (tlp_in.valid && tlp_in.int_owned && link_evt_in == '0)
        |=> !fatal_out && !correctable_out)
        else $error("internal packet checked");

    chk_malformed_fatal: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (tlp_in.valid && !tlp_in.int_owned && tlp_in.from_port && malformed
         && !tlp_in.lcrc_bad && !tlp_in.seq_mismatch && !tlp_in.ends_endb)
        |=> fatal_out)
        else $error("malformed packet not fatal");

    chk_no_port_check: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (tlp_in.valid && !tlp_in.from_port) |=> !fatal_out)
        else $error("internal move checked");

    chk_len_limit: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (tlp_in.valid && tlp_in.length >= max_payload_setting_in) |-> malformed)
        else $error("overlong packet passed");

    chk_pulse_single: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        ($rose(fatal_out) && !(tlp_in.valid && malformed)) |=> !fatal_out)
        else $error("fatal pulse stretched");

    // Remaining physical strobes
    chk_symbol_corr: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (link_evt_in.bad_symbol | link_evt_in.disparity) |=> correctable_out)
        else $error("symbol error not correctable");

    // Training breach alone must not look correctable
    chk_train_not_corr: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (link_evt_in.train_violation && !phys_corr && !dll_corr && !tlp_in.valid)
        |=> !correctable_out)
        else $error("training violation marked correctable");

    // Bad link packet and replay timeout
    chk_dllp_corr: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (link_evt_in.bad_dllp | link_evt_in.replay_timeout) |=> correctable_out)
        else $error("link packet error not correctable");

    // Flow control start-up breach
    chk_fcinit_uncorr: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        link_evt_in.fc_init_violation |=> nonfatal_out)
        else $error("flow control start-up breach not reported");

    // Out-of-order packet that is not a repeat
    chk_seq_corr: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (tlp_in.valid && !tlp_in.int_owned && tlp_in.seq_mismatch && !tlp_in.duplicate
         && !tlp_in.ends_endb) |=> correctable_out)
        else $error("sequence error not correctable");

    // Bad LCRC wins over any shape fault
    chk_lcrc_not_fatal: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (tlp_in.valid && !tlp_in.int_owned && tlp_in.lcrc_bad && !tlp_in.ends_endb)
        |=> !fatal_out)
        else $error("bad LCRC packet made fatal");

    // Stray completion on a clean external packet
    chk_unexp_nonfatal: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (tlp_in.valid && !tlp_in.int_owned && tlp_in.unexpected_cpl && !tlp_in.lcrc_bad
         && !tlp_in.seq_mismatch && !tlp_in.ends_endb) |=> nonfatal_out)
        else $error("unexpected completion not non-fatal");

    // Fatal only follows a packet taken at a port
    chk_fatal_cause: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        fatal_out |-> ($past(tlp_in.valid) && $past(tlp_in.from_port)))
        else $error("fatal pulse without port packet");

    // Non-fatal needs a link breach or a stray completion
    chk_nonfatal_cause: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        nonfatal_out |-> ($past(uncorr) || $past(tlp_in.unexpected_cpl)))
        else $error("non-fatal pulse without cause");

    // Dropped packet never also counts as fatal
    chk_drop_not_fatal: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        discard_out |-> !fatal_out)
        else $error("dropped packet raised fatal");

    // Internally owned packets leave the other classes quiet too
    chk_internal_quiet: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (tlp_in.valid && tlp_in.int_owned && link_evt_in == '0)
        |=> (!nonfatal_out && !discard_out))
        else $error("internal packet classified");

    // In-limit packet of a kind with no shape rule passes
    chk_len_quiet: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (tlp_in.valid && tlp_in.kind == NLEC_K_OTHER
         && tlp_in.length < max_payload_setting_in) |=> !fatal_out)
        else $error("in-limit packet made fatal");

    // Read requests carry exactly one dword
    chk_rd_shape: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (tlp_in.valid && (tlp_in.kind == NLEC_K_IO_RD || tlp_in.kind == NLEC_K_CFG_RD)
         && tlp_in.length != LEN_ONE) |-> malformed)
        else $error("long read request passed");

    // Write requests use traffic class zero
    chk_wr_tc: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (tlp_in.valid && (tlp_in.kind == NLEC_K_IO_WR || tlp_in.kind == NLEC_K_CFG_WR)
         && tlp_in.tc != TC_ZERO) |-> malformed)
        else $error("write request class passed");

    // End-to-end CRC presence alone never spoils a packet
    chk_ecrc_ignored: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (tlp_in.valid && tlp_in.kind == NLEC_K_OTHER && tlp_in.has_ecrc
         && tlp_in.length < max_payload_setting_in) |-> !malformed)
        else $error("end-to-end CRC judged");

    // Reports always head for the external root
    chk_report_ext: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        report_external_out)
        else $error("report not routed externally");

    // Correctable pulse drops when nothing new arrives
    chk_corr_single: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        ($rose(correctable_out) && !phys_corr && !dll_corr && !tlp_corr) |=> !correctable_out)
        else $error("correctable pulse stretched");

    // Reset clears every class by the next edge
    chk_reset_quiet: assert property (@(posedge clock_in)
        sys_rst_in |=> !(correctable_out || nonfatal_out || fatal_out || discard_out))
        else $error("class pulse during reset");

    // ****************************************************************
    // Coverage
    // ****************************************************************
    // Each class seen at least once, plus an internally owned packet
    cov_fatal:   cover property (@(posedge clock_in) fatal_out);
    cov_nonfat:  cover property (@(posedge clock_in) nonfatal_out);
    cov_discard: cover property (@(posedge clock_in) discard_out);
    cov_corr:    cover property (@(posedge clock_in) correctable_out);
    cov_int:     cover property (@(posedge clock_in) tlp_in.valid && tlp_in.int_owned);
endmodule

/* File: pkg/nlec_pkg.sv */
// Shared types and constants for the link error classifier.
// Assumes one 25 MHz clock and a synchronous active-high reset.
package nlec_pkg;

    // ****************************************************************
    // Widths and encodings
    // ****************************************************************
    localparam int unsigned LEN_W        = 10;
    localparam int unsigned DW_W         = 11;
    localparam logic [2:0]  TC_ZERO      = 3'h0;
    localparam logic [1:0]  ATTR_ZERO    = 2'h0;
    localparam logic [LEN_W-1:0] LEN_ONE = 10'h001;
    // Header sizes in doublewords, without and with end-to-end CRC
    localparam logic [DW_W-1:0] RD_DW_NOCRC  = 11'h003;
    localparam logic [DW_W-1:0] RD_DW_CRC    = 11'h004;
    localparam logic [DW_W-1:0] WR_DW_NOCRC  = 11'h004;
    localparam logic [DW_W-1:0] WR_DW_CRC    = 11'h005;
    localparam logic [DW_W-1:0] MW32_HDR_CRC = 11'h004;
    localparam logic [DW_W-1:0] MW32_HDR_NOCRC = 11'h003;

    // Kinds of received transaction packets
    typedef enum logic [2:0] {
        NLEC_K_OTHER,
        NLEC_K_IO_RD,
        NLEC_K_IO_WR,
        NLEC_K_CFG_RD,
        NLEC_K_CFG_WR,
        NLEC_K_MEM_WR32,
        NLEC_K_CPL
    } nlec_kind_type;

    // Summary of one received transaction packet, given at its end
    typedef struct packed {
        logic             valid;
        logic             from_port;   // Arrived on a link, not internal
        logic             int_owned;   // Belongs to internal bridge or endpoint
        logic             ends_endb;
        logic             lcrc_bad;
        logic             lcrc_inverted;
        logic             seq_mismatch;
        logic             duplicate;
        logic             unexpected_cpl;
        logic             has_ecrc;
        nlec_kind_type    kind;
        logic [LEN_W-1:0] length;
        logic [2:0]       tc;
        logic [1:0]       attr;
        logic [DW_W-1:0]  dw_count;
    } nlec_tlp_type;

    // One-cycle detection strobes from physical and link layers
    typedef struct packed {
        logic bad_symbol;
        logic disparity;
        logic framing;
        logic decode;
        logic train_violation;
        logic bad_dllp;
        logic replay_timeout;
        logic replay_rollover;
        logic fc_init_violation;
        logic acknak_bad_seq;
    } nlec_link_evt_type;

    // Error class pulses toward external endpoint reporting
    typedef struct packed {
        logic correctable;
        logic nonfatal;
        logic fatal;
        logic discard;
    } nlec_err_type;

endpackage

/* File: design/nlec_tlp_check.sv */
// Malformed-packet length and attribute check for one received packet.
// Assumes the packet summary is stable while valid is high.
`timescale 1ns/1ns
module nlec_tlp_check
    import nlec_pkg::*;
(
    input  wire nlec_pkg::nlec_tlp_type tlp_in,
    input  wire logic [LEN_W-1:0]       max_payload_setting_in,
    output logic                        malformed_out
);
    import nlec_pkg::*;

    // ****************************************************************
    // Combinational checks
    // ****************************************************************
    logic len_ok;
    logic small_ok;
    logic [DW_W-1:0] mw_expect;

    // Fixed small requests must carry one dword and default TC/ATTR
    always_comb begin
        len_ok    = tlp_in.length < max_payload_setting_in;
        small_ok  = (tlp_in.length == LEN_ONE) && (tlp_in.tc == TC_ZERO)
                    && (tlp_in.attr == ATTR_ZERO);
        mw_expect = DW_W'(tlp_in.length)
                    + (tlp_in.has_ecrc ? MW32_HDR_CRC : MW32_HDR_NOCRC);
        malformed_out = 1'b0;
        if (!len_ok) begin
            malformed_out = 1'b1;
        end
        unique case (tlp_in.kind)
            NLEC_K_IO_RD, NLEC_K_CFG_RD: begin
                if (!small_ok || tlp_in.dw_count !=
                    (tlp_in.has_ecrc ? RD_DW_CRC : RD_DW_NOCRC)) begin
                    malformed_out = 1'b1;
                end
            end
            NLEC_K_IO_WR, NLEC_K_CFG_WR: begin
                if (!small_ok || tlp_in.dw_count !=
                    (tlp_in.has_ecrc ? WR_DW_CRC : WR_DW_NOCRC)) begin
                    malformed_out = 1'b1;
                end
            end
            NLEC_K_MEM_WR32: begin
                if (tlp_in.dw_count != mw_expect) begin
                    malformed_out = 1'b1;
                end
            end
            default: begin
            end
        endcase
    end
endmodule

/* File: tb/nlec_far_model.sv */
// Far-side link partner model: drives event strobes and packet summaries.
// Assumes the bench calls its tasks from one process, one transfer at a time.
`timescale 1ns/1ns
module nlec_far_model
    import nlec_pkg::*;
(
    input  wire logic                   clock_in,
    output nlec_pkg::nlec_link_evt_type link_evt_out,
    output nlec_pkg::nlec_tlp_type      tlp_out
);
    import nlec_pkg::*;
    // ************************************************************
    // Transfer tasks
    // ************************************************************
    // Idle lines carry no strobe and no valid packet
    initial begin
        link_evt_out = '0;
        tlp_out      = '0;
    end

    // One strobe, held exactly one cycle so it is taken once
    task automatic send_evt(input int idx);
        @(posedge clock_in);
        link_evt_out <= nlec_link_evt_type'(10'h001 << idx);
        @(posedge clock_in);
        link_evt_out <= '0;
    endtask

    // One packet summary per cycle, valid dropped after the taking edge
    task automatic send_tlp(input nlec_tlp_type t);
        @(posedge clock_in);
        tlp_out <= t;
        @(posedge clock_in);
        tlp_out <= '0;
    endtask
endmodule

/* File: tb/ntb_link_error_classifier_bench.sv */
// Self-checking bench for the link error classifier.
// Assumes the far model drives strobes and packets; outputs are pulses.
`timescale 1ns/1ns
module ntb_link_error_classifier_bench;
    import nlec_pkg::*;
    logic              clock_in;
    logic              sys_rst_in;
    logic [LEN_W-1:0]  max_payload_setting;
    nlec_link_evt_type evt;
    nlec_tlp_type      tlp;
    logic              corr;
    logic              nf;
    logic              fat;
    logic              disc;
    logic              ext;
    int                n_errors;
    int                total_checks;
    int                cycles;

    // ************************************************************
    // Clock, reset, instances
    // ************************************************************
    initial begin
        clock_in = 1'b0;
        forever #20 clock_in = ~clock_in;
    end

    nlec_far_model u_far (.clock_in(clock_in), .link_evt_out(evt), .tlp_out(tlp));

    nlec_classifier u_dut (
        .clock_in              (clock_in),
        .sys_rst_in            (sys_rst_in),
        .link_evt_in           (evt),
        .tlp_in                (tlp),
        .max_payload_setting_in(max_payload_setting),
        .correctable_out       (corr),
        .nonfatal_out          (nf),
        .fatal_out             (fat),
        .discard_out           (disc),
        .report_external_out   (ext)
    );

    // Hang guard, well above the under two hundred cycles the tests need
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            finish_test();
        end
    end

    // ************************************************************
    // Helpers
    // ************************************************************
    // Clean port-received packet; callers spoil one field
    function automatic nlec_tlp_type pk(nlec_kind_type k, logic [LEN_W-1:0] len,
                                       logic [DW_W-1:0] dw, logic crc);
        nlec_tlp_type t;
        t           = '0;
        t.valid     = 1'b1;
        t.from_port = 1'b1;
        t.kind      = k;
        t.length    = len;
        t.dw_count  = dw;
        t.has_ecrc  = crc;
        return t;
    endfunction

    // Pulse must show in the answer cycle and be gone one cycle later
    task automatic chk(input string nm, input logic [3:0] exp);
        @(negedge clock_in);
        total_checks++;
        if ({corr, nf, fat, disc} !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, {corr, nf, fat, disc});
        end
        @(negedge clock_in);
        total_checks++;
        if ({corr, nf, fat, disc, ext} !== 5'h01) begin
            n_errors++;
            $display("[ERR] %s_after expected 01 seen %h", nm, {corr, nf, fat, disc, ext});
        end
    endtask

    task automatic run(input string nm, input nlec_tlp_type t, input logic [3:0] exp);
        u_far.send_tlp(t);
        chk(nm, exp);
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    // Every link strobe once; training, flow init, ack seq are uncorrectable
    task automatic test_link_events();
        for (int i = 0; i < 10; i++) begin
            u_far.send_evt(i);
            chk("link_evt", (i == 0 || i == 1 || i == 5) ? 4'h4 : 4'h8);
        end
        $display("test link_events done");
    endtask

    task automatic test_link_packets();
        nlec_tlp_type t;
        t = pk(NLEC_K_OTHER, 10'h004, 11'h007, 1'b0);
        t.ends_endb = 1'b1;
        t.lcrc_inverted = 1'b1;
        t.lcrc_bad = 1'b1;
        run("endb_drop", t, 4'h1);
        t = pk(NLEC_K_OTHER, 10'h004, 11'h007, 1'b0);
        t.lcrc_bad = 1'b1;
        run("lcrc_bad", t, 4'h8);
        t.lcrc_bad = 1'b0;
        t.seq_mismatch = 1'b1;
        run("seq_bad", t, 4'h8);
        t.duplicate = 1'b1;
        run("seq_dup", t, 4'h0);
        $display("test link_packets done");
    endtask

    task automatic test_transaction();
        nlec_tlp_type     t;
        logic [LEN_W-1:0] lim;
        lim = max_payload_setting;
        t = pk(NLEC_K_CPL, 10'h004, 11'h007, 1'b0);
        t.unexpected_cpl = 1'b1;
        run("cpl_unexp", t, 4'h4);
        run("len_below", pk(NLEC_K_OTHER, lim - 10'h001, 11'h003, 1'b1), 4'h0);
        run("len_equal", pk(NLEC_K_OTHER, lim, 11'h003, 1'b0), 4'h2);
        t = pk(NLEC_K_OTHER, lim, 11'h003, 1'b0);
        t.from_port = 1'b0;
        run("internal", t, 4'h0);
        t.from_port = 1'b1;
        t.int_owned = 1'b1;
        run("int_owned", t, 4'h0);
        run("mw_crc", pk(NLEC_K_MEM_WR32, 10'h005, 11'h009, 1'b1), 4'h0);
        run("mw_crc_bad", pk(NLEC_K_MEM_WR32, 10'h005, 11'h008, 1'b1), 4'h2);
        run("mw_nocrc", pk(NLEC_K_MEM_WR32, 10'h005, 11'h008, 1'b0), 4'h0);
        $display("test transaction done");
    endtask

    // All four read and write request kinds, each field spoiled in turn
    task automatic test_requests();
        nlec_kind_type   k;
        nlec_tlp_type    t;
        logic [DW_W-1:0] d;
        for (int i = 1; i <= 4; i++) begin
            k = nlec_kind_type'(i);
            d = (i == 1 || i == 3) ? RD_DW_NOCRC : WR_DW_NOCRC;
            run("req_ok", pk(k, LEN_ONE, d, 1'b0), 4'h0);
            run("req_ok_crc", pk(k, LEN_ONE, d + 11'h001, 1'b1), 4'h0);
            run("req_size", pk(k, LEN_ONE, d + 11'h001, 1'b0), 4'h2);
            run("req_len", pk(k, 10'h002, d, 1'b0), 4'h2);
            t = pk(k, LEN_ONE, d, 1'b0);
            t.tc = 3'h1;
            run("req_tc", t, 4'h2);
            t.tc = TC_ZERO;
            t.attr = 2'h2;
            run("req_attr", t, 4'h2);
        end
        $display("test requests done");
    endtask

    // Mid-run reset swallows a strobe; the next strobe is classed again
    task automatic test_reset();
        @(posedge clock_in);
        sys_rst_in <= 1'b1;
        u_far.send_evt(9);
        chk("reset_hold", 4'h0);
        @(posedge clock_in);
        sys_rst_in <= 1'b0;
        @(posedge clock_in);
        u_far.send_evt(9);
        chk("reset_after", 4'h8);
        $display("test reset done");
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        n_errors     = 0;
        total_checks = 0;
        cycles       = 0;
        sys_rst_in   = 1'b1;
        max_payload_setting = 10'h080;
        repeat (20) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        @(posedge clock_in);
        test_link_events();
        test_link_packets();
        test_transaction();
        test_requests();
        test_reset();
        finish_test();
    end
endmodule
